// *** include/pd_bmc_pkg.sv ***
// Constants and types shared by the biphase mark PHY
// Function
// - Every bit cell starts with a line transition; receiver delimits cells by edges.
// - A one adds a mid-cell transition; receiver decodes a mid-cell edge as one.
// - High/low imbalance over a transmitted packet stays within half a bit.
// - Transmission starts by driving the line low before the first encoded bit.
// - Receiver relocks when the first preamble edge is missed; if it first locks on a mid-cell edge it flags one code error.
// - After the last bit a closing edge is sent before the driver releases.
// - Traffic uses only the configuration-channel pin chosen by cable orientation.
// - Driver enables the selected pin only while transmitting, else high impedance.
// - Only one party transmits at once; all others keep their driver off. Start defers only on rxBusy, not over a far end's edgeless lead.
package pd_bmc_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int BIT_TIME_NS = 3334;
    localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] HALF_CYC = CNT_W'(BIT_CYCLES / 2);
    localparam logic [CNT_W-1:0] SHORT_MAX_CYC = CNT_W'((BIT_CYCLES * 3) / 4);
    localparam logic [CNT_W-1:0] EDGE_WINDOW_CYC = CNT_W'(BIT_CYCLES + BIT_CYCLES / 4);
    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic IDLE_LEVEL = 1'b0;
    localparam logic SYNC_RESET = 1'b0;

    typedef enum logic [1:0] {TX_IDLE, TX_LEAD, TX_CELL, TX_TAIL} tx_state_e;
endpackage : pd_bmc_pkg

// *** logic/bmc_rx_decoder.sv ***
// Biphase mark receiver: pin synchroniser, edge timing and bit decode
`timescale 1ns/1ps
`default_nettype none
module bmc_rx_decoder (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic enable,
    input wire logic lineIn,
    output logic rxBit,
    output logic rxBitValid,
    output logic rxFrameEnd,
    output logic rxCodeErr,
    output logic rxBusy
);
    logic syncA_r, syncB_r, syncC_r, level_r, level_nxt;
    logic busy_r, busy_nxt, half_r, half_nxt;
    logic bit_r, bit_nxt, valid_r, valid_nxt, end_r, end_nxt, err_r, err_nxt;
    logic [pd_bmc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic agree, edgeSeen;

    // Second and third stage must agree before a change counts
    assign agree = (syncB_r == syncC_r);
    assign edgeSeen = agree && (syncC_r != level_r);

    always_comb begin
        level_nxt = agree ? syncC_r : level_r;
        busy_nxt = busy_r;
        half_nxt = half_r;
        bit_nxt = bit_r;
        valid_nxt = 1'b0;
        end_nxt = 1'b0;
        err_nxt = 1'b0;
        cnt_nxt = cnt_r;
        if (!enable) begin
            // Own transmission is not decoded
            busy_nxt = 1'b0;
            half_nxt = 1'b0;
            cnt_nxt = pd_bmc_pkg::CNT_ZERO;
        end else if (edgeSeen) begin
            cnt_nxt = pd_bmc_pkg::CNT_ZERO;
            busy_nxt = 1'b1;
            // First edge only opens timing, so if it is missed the first bit is lost
            if (busy_r) begin
                if (cnt_r < pd_bmc_pkg::SHORT_MAX_CYC) begin
                    if (half_r) begin
                        bit_nxt = 1'b1;
                        valid_nxt = 1'b1;
                        half_nxt = 1'b0;
                    end else begin
                        half_nxt = 1'b1;
                    end
                end else if (half_r) begin
                    // Locked on a mid-cell edge: resync on this boundary
                    half_nxt = 1'b0;
                    err_nxt = 1'b1;
                end else begin
                    bit_nxt = 1'b0;
                    valid_nxt = 1'b1;
                end
            end
        end else if (busy_r) begin
            if (cnt_r == pd_bmc_pkg::EDGE_WINDOW_CYC) begin
                busy_nxt = 1'b0;
                half_nxt = 1'b0;
                cnt_nxt = pd_bmc_pkg::CNT_ZERO;
                err_nxt = half_r;
                end_nxt = !half_r;
            end else begin
                cnt_nxt = cnt_r + pd_bmc_pkg::CNT_ONE;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            syncA_r <= pd_bmc_pkg::SYNC_RESET;
            syncB_r <= pd_bmc_pkg::SYNC_RESET;
            syncC_r <= pd_bmc_pkg::SYNC_RESET;
            level_r <= pd_bmc_pkg::SYNC_RESET;
            busy_r <= 1'b0;
            half_r <= 1'b0;
            bit_r <= 1'b0;
            valid_r <= 1'b0;
            end_r <= 1'b0;
            err_r <= 1'b0;
            cnt_r <= pd_bmc_pkg::CNT_ZERO;
        end else begin
            syncA_r <= lineIn;
            syncB_r <= syncA_r;
            syncC_r <= syncB_r;
            level_r <= level_nxt;
            busy_r <= busy_nxt;
            half_r <= half_nxt;
            bit_r <= bit_nxt;
            valid_r <= valid_nxt;
            end_r <= end_nxt;
            err_r <= err_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign rxBit = bit_r;
    assign rxBitValid = valid_r;
    assign rxFrameEnd = end_r;
    assign rxCodeErr = err_r;
    assign rxBusy = busy_r;
endmodule : bmc_rx_decoder
`default_nettype wire

// *** logic/pd_biphase_mark_phy.sv ***
// Biphase mark PHY top: encoder, pin steering and receiver hookup
`timescale 1ns/1ps
`default_nettype none
module pd_biphase_mark_phy (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic orientFlipped,
    input wire logic txValid,
    input wire logic txData,
    input wire logic txLast,
    output logic txReady,
    output logic txBusy,
    output logic txDone,
    output logic txUnderrun,
    output logic rxBit,
    output logic rxBitValid,
    output logic rxFrameEnd,
    output logic rxCodeErr,
    output logic rxBusy,
    input wire logic configChannelPinAIn,
    output logic configChannelPinAOut,
    output logic configChannelPinAOe,
    input wire logic configChannelPinBIn,
    output logic configChannelPinBOut,
    output logic configChannelPinBOe,
    output logic configChannelPinSelected
);
    pd_bmc_pkg::tx_state_e state_r, state_nxt;
    logic [pd_bmc_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic second_r, second_nxt;
    logic level_r, level_nxt;
    logic bit_r, bit_nxt;
    logic last_r, last_nxt;
    logic selB_r, selB_nxt;
    logic oeA_r, oeA_nxt, oeB_r, oeB_nxt;
    logic done_r, done_nxt;
    logic under_r, under_nxt;
    logic drive;
    logic halfEnd;
    logic takeBit;
    logic rxLine;
    logic rxEnable;

    // Equal half cells keep the running disparity bounded
    assign halfEnd = (cnt_r == pd_bmc_pkg::HALF_CYC - pd_bmc_pkg::CNT_ONE);

    assign txReady = halfEnd && ((state_r == pd_bmc_pkg::TX_LEAD)
        || (state_r == pd_bmc_pkg::TX_CELL && second_r && !last_r));
    assign takeBit = txReady && txValid;
    assign txBusy = (state_r != pd_bmc_pkg::TX_IDLE);

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + pd_bmc_pkg::CNT_ONE;
        second_nxt = second_r;
        level_nxt = level_r;
        bit_nxt = bit_r;
        last_nxt = last_r;
        selB_nxt = selB_r;
        drive = 1'b1;
        done_nxt = 1'b0;
        under_nxt = 1'b0;
        unique case (state_r)
            pd_bmc_pkg::TX_IDLE: begin
                cnt_nxt = pd_bmc_pkg::CNT_ZERO;
                level_nxt = pd_bmc_pkg::IDLE_LEVEL;
                // Orientation only follows while idle, never mid-frame
                selB_nxt = orientFlipped;
                drive = 1'b0;
                // Defer while the wire carries someone else's frame
                if (txValid && !rxBusy) begin
                    state_nxt = pd_bmc_pkg::TX_LEAD;
                    drive = 1'b1;
                    level_nxt = 1'b0;
                end
            end
            pd_bmc_pkg::TX_LEAD: begin
                if (halfEnd) begin
                    cnt_nxt = pd_bmc_pkg::CNT_ZERO;
                    level_nxt = !level_r;
                    second_nxt = 1'b0;
                    if (takeBit) begin
                        bit_nxt = txData;
                        last_nxt = txLast;
                        state_nxt = pd_bmc_pkg::TX_CELL;
                    end else begin
                        under_nxt = 1'b1;
                        state_nxt = pd_bmc_pkg::TX_TAIL;
                    end
                end
            end
            pd_bmc_pkg::TX_CELL: begin
                if (halfEnd) begin
                    cnt_nxt = pd_bmc_pkg::CNT_ZERO;
                    if (!second_r) begin
                        second_nxt = 1'b1;
                        if (bit_r) begin
                            level_nxt = !level_r;
                        end
                    end else begin
                        second_nxt = 1'b0;
                        // Next cell start, or the closing edge after the last bit
                        level_nxt = !level_r;
                        if (last_r) begin
                            state_nxt = pd_bmc_pkg::TX_TAIL;
                        end else if (takeBit) begin
                            bit_nxt = txData;
                            last_nxt = txLast;
                        end else begin
                            // Source ran dry: end cleanly rather than stretch a cell
                            under_nxt = 1'b1;
                            state_nxt = pd_bmc_pkg::TX_TAIL;
                        end
                    end
                end
            end
            pd_bmc_pkg::TX_TAIL: begin
                // Closing edge holds half a cell so the far end can clock it
                if (halfEnd) begin
                    cnt_nxt = pd_bmc_pkg::CNT_ZERO;
                    state_nxt = pd_bmc_pkg::TX_IDLE;
                    level_nxt = pd_bmc_pkg::IDLE_LEVEL;
                    last_nxt = 1'b0;
                    drive = 1'b0;
                    done_nxt = 1'b1;
                end
            end
        endcase
        // Only the selected pin is ever enabled
        oeA_nxt = drive && !selB_nxt;
        oeB_nxt = drive && selB_nxt;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_r <= pd_bmc_pkg::TX_IDLE;
            cnt_r <= pd_bmc_pkg::CNT_ZERO;
            second_r <= 1'b0;
            level_r <= pd_bmc_pkg::IDLE_LEVEL;
            bit_r <= 1'b0;
            last_r <= 1'b0;
            selB_r <= 1'b0;
            oeA_r <= 1'b0;
            oeB_r <= 1'b0;
            done_r <= 1'b0;
            under_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            second_r <= second_nxt;
            level_r <= level_nxt;
            bit_r <= bit_nxt;
            last_r <= last_nxt;
            selB_r <= selB_nxt;
            oeA_r <= oeA_nxt;
            oeB_r <= oeB_nxt;
            done_r <= done_nxt;
            under_r <= under_nxt;
        end
    end

    assign configChannelPinAOut = level_r;
    assign configChannelPinBOut = level_r;
    assign configChannelPinAOe = oeA_r;
    assign configChannelPinBOe = oeB_r;
    assign configChannelPinSelected = selB_r;
    assign txDone = done_r;
    assign txUnderrun = under_r;

    // Receiver listens on the same pin the driver would use
    assign rxLine = selB_r ? configChannelPinBIn : configChannelPinAIn;
    // Decoder held off while we drive, so our own frame is not decoded
    assign rxEnable = (state_r == pd_bmc_pkg::TX_IDLE);

    bmc_rx_decoder rxDecoder (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .enable(rxEnable),
        .lineIn(rxLine),
        .rxBit(rxBit),
        .rxBitValid(rxBitValid),
        .rxFrameEnd(rxFrameEnd),
        .rxCodeErr(rxCodeErr),
        .rxBusy(rxBusy)
    );
endmodule : pd_biphase_mark_phy
`default_nettype wire

// *** tb/pd_bmc_sva.sv ***
// Port checker for the biphase mark PHY
`timescale 1ns/1ps
`default_nettype none
module pd_bmc_sva (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic txValid,
    input wire logic txData,
    input wire logic txReady,
    input wire logic txBusy,
    input wire logic txDone,
    input wire logic txUnderrun,
    input wire logic rxBitValid,
    input wire logic rxBusy,
    input wire logic configChannelPinAOut,
    input wire logic configChannelPinAOe,
    input wire logic configChannelPinBOe,
    input wire logic configChannelPinSelected
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic drv;
    logic out;
    assign drv = configChannelPinAOe | configChannelPinBOe;
    assign out = configChannelPinAOut;
    sequence take_s(b);
        txReady && txValid && txData == b;
    endsequence
    a_oe_exclusive: assert property (!(configChannelPinAOe && configChannelPinBOe))
        else $error("both pins driven");
    a_pin_a_only: assert property (configChannelPinAOe |-> !configChannelPinSelected)
        else $error("pin a driven while b chosen");
    a_pin_b_only: assert property (configChannelPinBOe |-> configChannelPinSelected)
        else $error("pin b driven while a chosen");
    a_lead_low: assert property ($rose(drv) |-> !out)
        else $error("frame does not open low");
    a_drive_busy: assert property (drv |-> txBusy)
        else $error("driver on while idle");
    a_done_release: assert property (txDone |-> !drv && $past(drv))
        else $error("done without release");
    a_cell_edge: assert property (txReady && txValid |=> $changed(out))
        else $error("no cell start edge");
    a_one_mid: assert property (take_s(1'b1) |-> ##17 $changed(out))
        else $error("one lacks mid edge");
    a_zero_flat: assert property (take_s(1'b0) |-> ##17 $stable(out))
        else $error("zero has mid edge");
    a_underrun_close: assert property (txUnderrun |-> ##[0:40] txDone)
        else $error("underrun not closed");
    a_rx_pulse: assert property (rxBitValid |=> !rxBitValid)
        else $error("bit strobe too long");
    a_defer_busy: assert property (!txBusy && rxBusy |=> !txBusy)
        else $error("frame started over busy wire");
endmodule : pd_bmc_sva
bind pd_biphase_mark_phy pd_bmc_sva chk (.core_clk, .sys_rst, .txValid, .txData, .txReady,
    .txBusy, .txDone, .txUnderrun, .rxBitValid, .rxBusy, .configChannelPinAOut,
    .configChannelPinAOe, .configChannelPinBOe, .configChannelPinSelected);
`default_nettype wire

// *** tb/bmc_remote_model.sv ***
// Far-end PD transmitter on one CC wire
`timescale 1ns/1ps
`default_nettype none
module bmc_remote_model (
    input wire logic core_clk,
    input wire logic peerOe,
    output logic lineOut,
    output logic lineOe
);
    initial begin
        lineOut = 1'b0;
        lineOe = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge core_clk);
    endtask : hold
    // Skip drops the very first edge, as a late receiver would see it
    task automatic send(input logic [7:0] bits, input int n, input logic skip);
        int i;
        while (peerOe) @(posedge core_clk);
        lineOe <= 1'b1;
        lineOut <= 1'b0;
        hold(16);
        for (i = 0; i < n; i++) begin
            if (!(skip && i == 0)) lineOut <= ~lineOut;
            hold(16);
            if (bits[i]) lineOut <= ~lineOut;
            hold(16);
        end
        lineOut <= ~lineOut;
        hold(16);
        lineOe <= 1'b0;
    endtask : send
endmodule : bmc_remote_model
`default_nettype wire

// *** tb/pd_biphase_mark_phy_bench.sv ***
// Self-checking bench for the biphase mark PHY
`timescale 1ns/1ps
`default_nettype none
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module pd_biphase_mark_phy_bench;
    logic core_clk = 1'b0, sys_rst = 1'b1, orientFlipped = 1'b0;
    logic txValid = 1'b0, txData = 1'b0, txLast = 1'b0, prevA = 1'b0;
    logic txReady, txBusy, txDone, txUnderrun, rxBit, rxBitValid, rxFrameEnd, rxCodeErr, rxBusy;
    logic configChannelPinAOut, configChannelPinAOe, configChannelPinBOut, configChannelPinBOe;
    logic configChannelPinSelected, peerOut, peerOe, wireA, wireB;
    logic [7:0] gotBits;
    int errors = 0, check_count = 0, edges = 0, imb = 0, maxImb = 0, nBits = 0, codeErrs = 0;
    // Released wire falls to the low bias level
    assign wireA = configChannelPinAOe ? configChannelPinAOut : 1'b0;
    assign wireB = configChannelPinBOe ? configChannelPinBOut : (peerOe ? peerOut : 1'b0);
    pd_biphase_mark_phy dut (.core_clk, .sys_rst, .orientFlipped, .txValid, .txData, .txLast,
        .txReady, .txBusy, .txDone, .txUnderrun, .rxBit, .rxBitValid, .rxFrameEnd, .rxCodeErr,
        .rxBusy, .configChannelPinAIn(wireA), .configChannelPinAOut, .configChannelPinAOe,
        .configChannelPinBIn(wireB), .configChannelPinBOut, .configChannelPinBOe,
        .configChannelPinSelected);
    bmc_remote_model peer (.core_clk, .peerOe(configChannelPinBOe), .lineOut(peerOut),
        .lineOe(peerOe));
    always #50 core_clk = ~core_clk;
    // Sampled mid-cycle so register updates have landed
    always @(negedge core_clk) begin
        if (rxBitValid) begin
            gotBits[nBits] = rxBit;
            nBits++;
        end
        if (rxCodeErr) codeErrs++;
        if (configChannelPinAOe && wireA != prevA) edges++;
        prevA = wireA;
        if (configChannelPinAOe) imb += configChannelPinAOut ? 1 : -1;
        if (imb > maxImb || -imb > maxImb) maxImb = imb < 0 ? -imb : imb;
    end
    task automatic end_of_test;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    task automatic wait_hi(ref logic s);
        int n;
        // Look half a cycle on, never at the edge that launches the value
        @(negedge core_clk);
        for (n = 0; n < 200 && s !== 1'b1; n++) @(negedge core_clk);
        `CHECK(s, 1'b1)
    endtask : wait_hi
    task automatic tx_frame;
        int i;
        logic [2:0] bits = 3'h5;
        @(posedge core_clk);
        txValid <= 1'b1;
        for (i = 0; i < 3; i++) begin
            txData <= bits[i];
            txLast <= (i == 2);
            wait_hi(txReady);
            @(posedge core_clk);
        end
        txValid <= 1'b0;
        wait_hi(txDone);
        `CHECK(edges, 6)
        `CHECK(maxImb <= 16, 1'b1)
    endtask : tx_frame
    task automatic rx_frame;
        @(posedge core_clk);
        orientFlipped <= 1'b1;
        repeat (4) @(posedge core_clk);
        `CHECK(configChannelPinSelected, 1'b1)
        peer.send(8'h04, 3, 1'b1);
        wait_hi(rxFrameEnd);
        `CHECK(nBits, 2)
        `CHECK(gotBits[1:0], 2'h2)
        `CHECK(rxBusy, 1'b0)
        `CHECK(codeErrs, 0)
    endtask : rx_frame
    // First edge seen is a mid-cell one: one error, then relock; a start is deferred meanwhile
    task automatic rx_relock;
        @(posedge core_clk);
        fork
            peer.send(8'h01, 3, 1'b1);
            begin
                repeat (40) @(posedge core_clk);
                txValid <= 1'b1;
                repeat (20) @(posedge core_clk);
                `CHECK(txBusy, 1'b0)
                txValid <= 1'b0;
            end
        join
        wait_hi(rxFrameEnd);
        `CHECK(codeErrs, 1)
        `CHECK(nBits, 3)
        `CHECK(gotBits[2], 1'b0)
    endtask : rx_relock
    task automatic tx_underrun;
        @(posedge core_clk);
        orientFlipped <= 1'b0;
        @(posedge core_clk);
        txValid <= 1'b1;
        @(posedge core_clk);
        txValid <= 1'b0;
        wait_hi(txUnderrun);
        wait_hi(txDone);
        `CHECK(configChannelPinAOe, 1'b0)
        `CHECK(txBusy, 1'b0)
    endtask : tx_underrun
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        `CHECK(configChannelPinAOe, 1'b0)
        tx_frame();
        rx_frame();
        rx_relock();
        tx_underrun();
        end_of_test();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge core_clk);
        errors++;
        end_of_test();
    end
endmodule : pd_biphase_mark_phy_bench
`default_nettype wire
